// file: verilog/spc_pkg.sv
// package of constants and types for the sleep and power controller
package spc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] SPC_SLEEP_CONTROL_OFS = 8'h3a;
   localparam logic [7:0] SPC_CLOCK_STOP_OFS    = 8'h35;
   localparam logic [7:0] SPC_COMPARATOR_OFS    = 8'h3b;
   localparam logic [7:0] SPC_STATUS_OFS        = 8'h3c;
   localparam logic [7:0] SPC_SLEEP_CONTROL_RST = 8'h00;
   localparam logic [7:0] SPC_CLOCK_STOP_RST    = 8'h00;
   localparam logic [7:0] SPC_COMPARATOR_RST    = 8'h00;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SPC_PERMIT_BIT    = 0;
   localparam int SPC_KIND_LSB      = 1;
   localparam int SPC_KIND_MSB      = 3;
   localparam int SPC_STOP_TIMER    = 0;
   localparam int SPC_STOP_CONV     = 1;
   localparam int SPC_CMP_OFF_BIT   = 7;
   localparam int SPC_CONV_EN_BIT   = 0;
   // ---------------------------------------------------------------
   // mode codes and timing
   // ---------------------------------------------------------------
   localparam logic [2:0] SPC_KIND_IDLE    = 3'h0;
   localparam logic [2:0] SPC_KIND_NOISE   = 3'h1;
   localparam logic [2:0] SPC_KIND_PDOWN   = 3'h2;
   localparam logic [2:0] SPC_KIND_STANDBY = 3'h4;
   localparam logic [3:0] SPC_WAKE_HOLD_CYC = 4'h4;
   localparam logic [3:0] SPC_OSC_START_CYC = 4'h6;

   typedef enum logic [2:0] {
      SPC_ACTIVE,
      SPC_SLEEPING,
      SPC_OSC_START,
      SPC_HOLD
   } spc_state_e;

   // wake sources, one bit per source
   typedef struct packed {
      logic ext_level;
      logic ext_edge;
      logic pin_change;
      logic conv;
      logic comparator;
      logic other_io;
      logic watchdog;
      logic supply_monitor;
   } spc_wake_s;

   // clock gates towards the domains
   typedef struct packed {
      logic core;
      logic nonvolatile;
      logic peripheral;
      logic conv;
      logic main_osc;
   } spc_clk_en_s;
endpackage

// file: verilog/spc_sleep_power_controller.sv
// sleep mode, clock gating and wake logic of the small controller
//
// How it works
// R1 - idle stops core and nonvolatile clocks; peripheral, converter, oscillator run
// R2 - noise-reduction also stops the peripheral clock; converter and oscillator run
// R3 - power-down stops oscillator and all clocks; wake by watchdog, level line0, pins
// R4 - standby equals power-down but the main oscillator keeps running; the code does not force the comparator off in standby
// R5 - sleep entered only if permit bit is 1 at the sleep instruction
// R6 - mode codes: 000 idle, 001 noise, 010 power-down, 100 standby
// R7 - after interrupt wake, core stays halted four cycles past start-up
// R8 - sleep and wake never touch register file or data memory
// R9 - reset during sleep wakes the core and restarts at reset vector
// R10 - in deeper modes line zero wakes only when level-sensitive
// R11 - idle wakes on all sources; noise mode on ext, pin, conv, watchdog, supply
// R12 - enabled converter starts a conversion on entering idle or noise mode
// R13 - stopped peripheral is frozen and its registers are blocked
// R14 - clearing the stop bit restarts the peripheral from its saved state
// R15 - per-peripheral stopping matters only in active and idle modes
// R16 - power-down forces the comparator off whatever its enable
// R17 - enabled converter stays on in sleep; off then on forces extended conversion
// R18 - enabled watchdog keeps running in every sleep mode
// R19 - without peripheral clock, input buffers off except wake detectors
// R20 - comparator-off bit powers comparator down and drops it as wake source
// R21 - mode field sits at bits three to one of sleep control
// R22 - permit bit sits at bit zero of sleep control
// R23 - sleep with permit clear or reserved mode acts as no-operation
`timescale 1ns/10ps
`default_nettype none
module spc_sleep_power_controller
   import spc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata_q,
   input  wire logic        sleep_instr,
   input  wire spc_wake_s   wake_req,
   input  wire logic        ext_line_zero_level,
   input  wire logic        conv_enabled,
   input  wire logic        watchdog_enabled,
   input  wire logic [3:0]  wake_pin_mask,
   output spc_clk_en_s      clk_en_q,
   output logic      [1:0]  periph_clk_en_q,
   output logic      [1:0]  periph_access_ok_q,
   output logic             core_halt_q,
   output logic             sleep_nop_q,
   output logic             conv_start_q,
   output logic             conv_extended_q,
   output logic             comparator_on_q,
   output logic             watchdog_run_q,
   output logic      [3:0]  input_buf_en_q,
   output logic             restart_at_reset_q
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic kind_valid(input logic [2:0] k);
      kind_valid = (k == SPC_KIND_IDLE) || (k == SPC_KIND_NOISE) ||
                   (k == SPC_KIND_PDOWN) || (k == SPC_KIND_STANDBY); // R6
   endfunction

   function automatic logic wake_ok(input logic [2:0] k, input spc_wake_s w,
                                    input logic cmp_off, input logic lvl);
      logic deep;
      deep = (k == SPC_KIND_PDOWN) || (k == SPC_KIND_STANDBY);
      if (k == SPC_KIND_IDLE) begin
         wake_ok = w.ext_level | w.ext_edge | w.pin_change | w.conv | w.other_io |
                   w.watchdog | w.supply_monitor | (w.comparator & ~cmp_off); // R11 R20
      end else if (k == SPC_KIND_NOISE) begin
         wake_ok = (w.ext_level & lvl) | w.pin_change | w.conv | w.watchdog |
                   w.supply_monitor; // R10 R11
      end else if (deep) begin
         wake_ok = (w.ext_level & lvl) | w.pin_change | w.watchdog; // R3 R4 R10
      end else begin
         wake_ok = 1'b0;
      end
   endfunction

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] sleep_control_q;
   logic [7:0] clock_stop_q;
   logic [7:0] comparator_ctrl_q;
   spc_state_e state_q;
   logic [2:0] active_kind_q;
   logic [3:0] count_q;
   logic       conv_en_prev_q;
   logic       conv_was_off_q;
   logic       wake_by_irq_q;
   logic [2:0] kind;
   logic       permit;
   logic       sleeping;

   assign kind   = sleep_control_q[SPC_KIND_MSB:SPC_KIND_LSB]; // R21
   assign permit = sleep_control_q[SPC_PERMIT_BIT]; // R22
   assign sleeping = (state_q != SPC_ACTIVE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_control_q   <= SPC_SLEEP_CONTROL_RST;
         clock_stop_q      <= SPC_CLOCK_STOP_RST;
         comparator_ctrl_q <= SPC_COMPARATOR_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            SPC_SLEEP_CONTROL_OFS: sleep_control_q <= {4'h0, reg_wdata[3:0]};
            SPC_CLOCK_STOP_OFS:    clock_stop_q <= {6'h00, reg_wdata[1:0]}; // R13 R14
            SPC_COMPARATOR_OFS:    comparator_ctrl_q <= reg_wdata & 8'h81;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            SPC_SLEEP_CONTROL_OFS: reg_rdata_q <= sleep_control_q;
            SPC_CLOCK_STOP_OFS:    reg_rdata_q <= clock_stop_q;
            SPC_COMPARATOR_OFS:    reg_rdata_q <= comparator_ctrl_q;
            SPC_STATUS_OFS:        reg_rdata_q <= {2'h0, conv_was_off_q, sleeping,
                                                   1'b0, active_kind_q};
            default:               reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // sleep sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q       <= SPC_ACTIVE; // R9
         active_kind_q <= SPC_KIND_IDLE;
         count_q       <= 4'h0;
         wake_by_irq_q <= 1'b0;
      end else begin
         case (state_q)
            SPC_ACTIVE: begin
               if (sleep_instr && permit && kind_valid(kind)) begin // R5 R23
                  state_q       <= SPC_SLEEPING;
                  active_kind_q <= kind;
               end
            end
            SPC_SLEEPING: begin
               if (wake_ok(active_kind_q, wake_req, comparator_ctrl_q[SPC_CMP_OFF_BIT],
                           ext_line_zero_level)) begin // R10
                  wake_by_irq_q <= 1'b1;
                  count_q       <= 4'h0;
                  state_q <= (active_kind_q == SPC_KIND_PDOWN) ? SPC_OSC_START : SPC_HOLD;
               end
            end
            SPC_OSC_START: begin
               if (count_q == SPC_OSC_START_CYC - 4'h1) begin
                  count_q <= 4'h0;
                  state_q <= SPC_HOLD;
               end else begin
                  count_q <= count_q + 4'h1;
               end
            end
            SPC_HOLD: begin
               if (count_q == SPC_WAKE_HOLD_CYC - 4'h1) begin // R7
                  count_q       <= 4'h0;
                  wake_by_irq_q <= 1'b0;
                  state_q       <= SPC_ACTIVE;
               end else begin
                  count_q <= count_q + 4'h1;
               end
            end
            default: state_q <= SPC_ACTIVE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // clock gates, only gating so state and memory are kept
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_en_q           <= '1;
         periph_clk_en_q    <= 2'h3;
         periph_access_ok_q <= 2'h3;
         core_halt_q        <= 1'b0;
      end else begin
         core_halt_q <= (state_q != SPC_ACTIVE) &&
                        !(state_q == SPC_HOLD && count_q == SPC_WAKE_HOLD_CYC - 4'h1); // R7 R8
         if (state_q == SPC_SLEEPING) begin
            clk_en_q.core        <= 1'b0; // R1 R8
            clk_en_q.nonvolatile <= 1'b0; // R1
            clk_en_q.peripheral  <= (active_kind_q == SPC_KIND_IDLE); // R1 R2
            clk_en_q.conv        <= (active_kind_q == SPC_KIND_IDLE) ||
                                    (active_kind_q == SPC_KIND_NOISE); // R2
            clk_en_q.main_osc    <= (active_kind_q != SPC_KIND_PDOWN); // R3 R4
         end else if (state_q == SPC_ACTIVE) begin
            clk_en_q <= '1;
         end else begin
            clk_en_q.main_osc <= 1'b1;
         end
         if (state_q == SPC_ACTIVE ||
             (state_q == SPC_SLEEPING && active_kind_q == SPC_KIND_IDLE)) begin // R15
            periph_clk_en_q <= ~clock_stop_q[1:0]; // R13 R14
         end else begin
            periph_clk_en_q <= 2'h0; // R15
         end
         periph_access_ok_q <= ~clock_stop_q[1:0]; // R13
      end
   end

   // ---------------------------------------------------------------
   // analog and watchdog side effects
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_start_q    <= 1'b0;
         conv_extended_q <= 1'b0;
         conv_en_prev_q  <= 1'b0;
         conv_was_off_q  <= 1'b1;
         sleep_nop_q     <= 1'b0;
      end else begin
         sleep_nop_q    <= (state_q == SPC_ACTIVE) && sleep_instr &&
                           !(permit && kind_valid(kind)); // R23
         conv_en_prev_q <= conv_enabled; // R17
         conv_start_q   <= (state_q == SPC_ACTIVE) && sleep_instr && permit && conv_enabled &&
                           ((kind == SPC_KIND_IDLE) || (kind == SPC_KIND_NOISE)); // R12
         if (!conv_enabled) begin
            conv_was_off_q <= 1'b1; // R17
         end else if (conv_start_q) begin
            conv_was_off_q <= 1'b0;
         end
         conv_extended_q <= conv_enabled && conv_was_off_q; // R17
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         comparator_on_q    <= 1'b1;
         watchdog_run_q     <= 1'b0;
         input_buf_en_q     <= 4'hf;
         restart_at_reset_q <= 1'b1;
      end else begin
         comparator_on_q <= !comparator_ctrl_q[SPC_CMP_OFF_BIT] &&
                            !(state_q == SPC_SLEEPING &&
                              active_kind_q == SPC_KIND_PDOWN); // R16 R20
         watchdog_run_q <= watchdog_enabled; // R18
         if (state_q != SPC_ACTIVE && active_kind_q != SPC_KIND_IDLE) begin
            input_buf_en_q <= wake_pin_mask; // R19
         end else begin
            input_buf_en_q <= 4'hf;
         end
         restart_at_reset_q <= 1'b0; // R9
      end
   end
endmodule
`default_nettype wire

// file: dv/spc_core_model.sv
// core model that executes the sleep instruction on command
`timescale 1ns/10ps
`default_nettype none
module spc_core_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic run_sleep,
   input  wire logic core_halt_q,
   output var  logic sleep_instr
);
   // one sleep instruction per command, never while halted
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_instr <= 1'b0;
      end else begin
         sleep_instr <= run_sleep && !core_halt_q && !sleep_instr;
      end
   end
endmodule
`default_nettype wire

// file: dv/spc_sleep_power_controller_assertions.sv
// checker of sleep entry, clock gating and sleep-side outputs
`timescale 1ns/10ps
`default_nettype none
module spc_assertions
   import spc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        sleep_instr,
   input wire logic        conv_enabled,
   input wire logic        watchdog_enabled,
   input wire logic [3:0]  wake_pin_mask,
   input wire spc_clk_en_s clk_en_q,
   input wire logic        core_halt_q,
   input wire logic        sleep_nop_q,
   input wire logic        conv_start_q,
   input wire logic        comparator_on_q,
   input wire logic        watchdog_run_q,
   input wire logic [3:0]  input_buf_en_q
);
   logic [3:0] ctl_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_q <= 4'h0;
      end else if (reg_wr && reg_addr == SPC_SLEEP_CONTROL_OFS) begin
         ctl_q <= reg_wdata[3:0];
      end
   end
   wire logic [2:0] kind = ctl_q[SPC_KIND_MSB:SPC_KIND_LSB];
   wire logic [4:0] ce = clk_en_q;
   wire logic legal = kind == SPC_KIND_IDLE || kind == SPC_KIND_NOISE
                      || kind == SPC_KIND_PDOWN || kind == SPC_KIND_STANDBY;
   wire logic ok = ctl_q[SPC_PERMIT_BIT] && legal;
   wire logic enter = sleep_instr && !core_halt_q && ok;
   wire logic refuse = sleep_instr && !core_halt_q && !ok;
   wire logic deep = core_halt_q && !clk_en_q.peripheral;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sleep_enter_a: assert property (enter |-> ##2 core_halt_q)
      else $error("sleep entry did not halt the core");
   sleep_refuse_a: assert property (refuse |-> ##1 !core_halt_q [*3])
      else $error("refused sleep halted the core");
   nop_pulse_a: assert property (refuse |-> ##1 sleep_nop_q)
      else $error("refused sleep gave no no-operation pulse");
   idle_gates_a: assert property (enter && kind == SPC_KIND_IDLE |-> ##2 ce == 5'h07)
      else $error("idle clock gates wrong");
   noise_gates_a: assert property (enter && kind == SPC_KIND_NOISE |-> ##2 ce == 5'h03)
      else $error("noise mode clock gates wrong");
   pdown_gates_a: assert property (enter && kind == SPC_KIND_PDOWN |->
      ##2 ce == 5'h00 && !comparator_on_q) else $error("power-down gates wrong");
   standby_gates_a: assert property (enter && kind == SPC_KIND_STANDBY |-> ##2 ce == 5'h01)
      else $error("standby clock gates wrong");
   watchdog_keep_a: assert property (core_halt_q && $past(watchdog_enabled) |-> watchdog_run_q)
      else $error("watchdog stopped in sleep");
   input_bufs_a: assert property ($past(deep) && deep |-> input_buf_en_q == wake_pin_mask)
      else $error("input buffers wrong in deep sleep");
   conv_start_a: assert property (enter && conv_enabled && kind[2:1] == 2'h0
      |-> ##[1:3] conv_start_q) else $error("no conversion on entry");
   cover property (enter && kind == SPC_KIND_PDOWN);
   cover property (refuse);
   cover property (deep ##1 !core_halt_q);
endmodule
bind spc_sleep_power_controller spc_assertions u_chk (.clk, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .sleep_instr, .conv_enabled, .watchdog_enabled, .wake_pin_mask, .clk_en_q,
   .core_halt_q, .sleep_nop_q, .conv_start_q, .comparator_on_q, .watchdog_run_q,
   .input_buf_en_q);
`default_nettype wire

// file: dv/spc_sleep_power_controller_tb.sv
// self-checking bench of the sleep and power controller
`timescale 1ns/10ps
`default_nettype none
module spc_sleep_power_controller_tb
   import spc_pkg::*;
;
   logic        clk, rst_b, reg_wr, reg_rd, run_sleep, sleep_instr, conv_enabled;
   logic        watchdog_enabled, core_halt_q, conv_start_q, conv_extended_q;
   logic        comparator_on_q, watchdog_run_q, restart_at_reset_q, lvl_cfg;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
   logic [3:0]  wake_pin_mask, input_buf_en_q;
   logic [1:0]  periph_clk_en_q, periph_access_ok_q;
   spc_wake_s   wake_req;
   spc_clk_en_s clk_en_q;
   int          num_errors, comparisons;
   logic [2:0]  kinds [4] = '{SPC_KIND_IDLE, SPC_KIND_NOISE, SPC_KIND_PDOWN, SPC_KIND_STANDBY};
   logic [4:0]  gates [4] = '{5'h07, 5'h03, 5'h00, 5'h01};
   int          holds [4] = '{4, 4, 10, 4};
   spc_sleep_power_controller u_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .sleep_instr, .wake_req, .ext_line_zero_level(lvl_cfg), .conv_enabled,
      .watchdog_enabled, .wake_pin_mask, .clk_en_q, .periph_clk_en_q, .periph_access_ok_q,
      .core_halt_q, .sleep_nop_q(), .conv_start_q, .conv_extended_q, .comparator_on_q,
      .watchdog_run_q, .input_buf_en_q, .restart_at_reset_q);
   spc_core_model u_core (.clk, .rst_b, .run_sleep, .core_halt_q, .sleep_instr);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // access and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata_q);
   endtask
   task automatic slp(input logic [3:0] ctl, input logic exp);
      wr(SPC_SLEEP_CONTROL_OFS, {4'h0, ctl});
      @(posedge clk);
      run_sleep <= 1'b1;
      @(posedge clk);
      run_sleep <= 1'b0;
      repeat (4) @(posedge clk);
      chk("core_halt", {7'h0, exp}, {7'h0, core_halt_q});
   endtask
   task automatic wk(input logic [7:0] src, input int lo);
      int n;
      n = 0;
      @(posedge clk);
      wake_req <= src;
      while (core_halt_q !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      wake_req <= '0;
      chk("wake_delay_in_window", 8'h01, {7'h0, n >= lo && n <= lo + 4});
   endtask
   task automatic ign(input logic [7:0] src);
      @(posedge clk);
      wake_req <= src;
      repeat (12) @(posedge clk);
      wake_req <= '0;
      chk("still_halted", 8'h01, {7'h0, core_halt_q});
   endtask
   task automatic stop(input logic [7:0] d, input logic [7:0] exp);
      wr(SPC_CLOCK_STOP_OFS, d);
      repeat (2) @(posedge clk);
      chk("periph_clk_en", exp, {6'h0, periph_clk_en_q});
      chk("periph_access_ok", exp, {6'h0, periph_access_ok_q});
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      {reg_wr, reg_rd, run_sleep, reg_addr, reg_wdata, wake_req} = '0;
      {conv_enabled, watchdog_enabled, wake_pin_mask} = 6'h3a;
      {num_errors, comparisons} = '0;
      lvl_cfg = 1'b1;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd(SPC_SLEEP_CONTROL_OFS, SPC_SLEEP_CONTROL_RST);
      rd(SPC_CLOCK_STOP_OFS, SPC_CLOCK_STOP_RST);
      rd(8'h3f, 8'h00);
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) begin
         slp({kinds[i], 1'b1}, 1'b1);
         chk("clk_en", {3'h0, gates[i]}, {3'h0, clk_en_q});
         wk(8'h02, holds[i]);
         rd(SPC_SLEEP_CONTROL_OFS, {4'h0, kinds[i], 1'b1});
      end
      $display("test modes done");
      for (int i = 0; i < 8; i++) begin
         slp({i[2:0], i[2:0] == 3'h3 || i[2:0] > 3'h4}, 1'b0);
      end
      $display("test refusals done");
      slp({SPC_KIND_NOISE, 1'b1}, 1'b1);
      ign(8'h44);
      wk(8'h80, 4);
      slp({SPC_KIND_PDOWN, 1'b1}, 1'b1);
      ign(8'h5c);
      wk(8'h20, 10);
      slp({SPC_KIND_IDLE, 1'b1}, 1'b1);
      wk(8'h04, 4);
      lvl_cfg <= 1'b0;
      slp({SPC_KIND_PDOWN, 1'b1}, 1'b1);
      ign(8'h80);
      wk(8'h20, 10);
      lvl_cfg <= 1'b1;
      $display("test wake_sources done");
      wr(SPC_COMPARATOR_OFS, 8'h80);
      repeat (2) @(posedge clk);
      chk("comparator_on", 8'h00, {7'h0, comparator_on_q});
      slp({SPC_KIND_IDLE, 1'b1}, 1'b1);
      ign(8'h08);
      wk(8'h02, 4);
      wr(SPC_COMPARATOR_OFS, 8'h00);
      stop(8'h01, 8'h02);
      rd(SPC_CLOCK_STOP_OFS, 8'h01);
      stop(8'h02, 8'h01);
      stop(8'h00, 8'h03);
      @(posedge clk);
      conv_enabled <= 1'b0;
      repeat (3) @(posedge clk);
      conv_enabled <= 1'b1;
      repeat (3) @(posedge clk);
      chk("conv_extended", 8'h01, {7'h0, conv_extended_q});
      $display("test peripherals done");
      slp({SPC_KIND_PDOWN, 1'b1}, 1'b1);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1;
      chk("core_halt_reset", 8'h00, {7'h0, core_halt_q});
      chk("restart_at_reset", 8'h01, {7'h0, restart_at_reset_q});
      @(posedge clk);
      rst_b <= 1'b1;
      rd(SPC_SLEEP_CONTROL_OFS, 8'h00);
      $display("test reset_in_sleep done");
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("watchdog expired");
      summarize();
   end
endmodule
`default_nettype wire
